/* rtl/sch_handler.sv */
/*
 Standby command handler: task-file style registers on Avalon-MM, decode and
 execution of the timed and immediate standby commands, status/error report,
 standby timer control and a masked interrupt.
 Assumes a host that respects the ready bit and a single 25 MHz clock.
*/
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
module sch_handler
   import sch_pkg::*;
#(
   parameter logic [255:0][sch_pkg::SCH_TMR_W-1:0] PERIOD_LUT = '{default: 24'h0004e2}
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic activity,
   output logic standby_q,
   output logic timer_en_q,
   output logic drive_sel_q,
   output logic irq
);
   import sch_pkg::*;

   sch_state_t state_q;
   sch_req_t req;
   logic [7:0] count_q;
   logic [7:0] drvsel_q;
   logic [7:0] cmd_q;
   logic [7:0] status_q;
   logic [7:0] error_q;
   logic [2:0] ctrl_q;
   logic [SCH_IRQ_W-1:0] irq_stat_q;
   logic [SCH_IRQ_W-1:0] irq_mask_q;
   logic ack_q;
   logic wr_take;
   logic cmd_wr;
   logic abort_now;
   logic done_ev;
   logic abort_ev;
   logic expire;
   logic tmr_load;
   logic [SCH_IRQ_W-1:0] irq_set;

   assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};
   assign wr_take = req.write && ack_q;
   assign cmd_wr = wr_take && req.address == SCH_OFF_CMD && state_q == SCH_IDLE;
   assign abort_now = !ctrl_q[SCH_CT_PM_SUP] || ctrl_q[SCH_CT_CANT];
   assign done_ev = state_q == SCH_EXEC && !abort_now;
   assign abort_ev = state_q == SCH_EXEC && abort_now;
   assign tmr_load = done_ev && cmd_q == SCH_CMD_STANDBY;
   assign irq_set = {expire, abort_ev, done_ev};

   // Bus answer: one wait cycle, then accept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (req.read || req.write) && !ack_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((req.read || req.write) && !ack_q);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= '0;
      end else if (req.read && !ack_q) begin
         case (req.address)
            SCH_OFF_COUNT: avs_readdata <= {24'h000000, count_q};
            SCH_OFF_DRVSEL: avs_readdata <= {24'h000000, drvsel_q};
            SCH_OFF_STATUS: avs_readdata <= {24'h000000, status_q};
            SCH_OFF_ERROR: avs_readdata <= {24'h000000, error_q};
            SCH_OFF_CTRL: avs_readdata <= {29'h0, ctrl_q};
            SCH_OFF_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_q};
            SCH_OFF_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_q};
            default: avs_readdata <= '0;
         endcase
      end
   end

   // Task-file inputs; count may not change while a command runs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
         drvsel_q <= '0;
         ctrl_q <= SCH_CTRL_RST;
         irq_mask_q <= '0;
      end else if (wr_take) begin
         case (req.address)
            SCH_OFF_COUNT: if (state_q == SCH_IDLE) count_q <= req.writedata[7:0];
            SCH_OFF_DRVSEL: drvsel_q <= req.writedata[7:0];
            SCH_OFF_CTRL: ctrl_q <= req.writedata[2:0];
            SCH_OFF_IRQ_MASK: irq_mask_q <= req.writedata[SCH_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drive_sel_q <= 1'b0;
      end else begin
         drive_sel_q <= drvsel_q[SCH_DH_DEV];
      end
   end

   // Command sequencer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= SCH_IDLE;
         cmd_q <= '0;
      end else begin
         case (state_q)
            SCH_IDLE: if (cmd_wr && status_q[SCH_ST_DRDY]) begin
               cmd_q <= req.writedata[7:0];
               state_q <= SCH_EXEC;
            end
            SCH_EXEC: state_q <= SCH_DONE;
            SCH_DONE: state_q <= SCH_IDLE;
            default: state_q <= SCH_IDLE;
         endcase
      end
   end

   // Status and error report
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_q <= SCH_STATUS_RST;
         error_q <= '0;
      end else if (state_q == SCH_IDLE && cmd_wr) begin
         status_q[SCH_ST_BSY] <= 1'b1;
         status_q[SCH_ST_DRDY] <= 1'b0;
      end else if (done_ev) begin
         status_q <= '0;
         status_q[SCH_ST_DRDY] <= 1'b1;
         error_q <= '0;
      end else if (abort_ev) begin
         error_q <= '0;
         error_q[SCH_ER_ABRT] <= 1'b1;
         status_q <= '0;
         status_q[SCH_ST_DRDY] <= 1'b1;
         status_q[SCH_ST_DF] <= ctrl_q[SCH_CT_FAULT];
         status_q[SCH_ST_ERR] <= 1'b1;
      end
   end

   // Power state and timer enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         standby_q <= 1'b0;
         timer_en_q <= 1'b0;
      end else if (done_ev && (cmd_q == SCH_CMD_STANDBY || cmd_q == SCH_CMD_STANDBY_NOW)) begin
         standby_q <= 1'b1;
         if (cmd_q == SCH_CMD_STANDBY) begin
            timer_en_q <= count_q != 8'h00;
         end
      end else if (activity) begin
         standby_q <= 1'b0;
      end else if (expire) begin
         standby_q <= 1'b1;
      end
   end

   sch_timer #(.W(SCH_TMR_W)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(tmr_load),
      .enable(timer_en_q && !standby_q),
      .period(PERIOD_LUT[count_q]),
      .restart(activity),
      .expire(expire)
   );

   // Interrupts: set wins over write-one-to-clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat_q <= '0;
      end else if (wr_take && req.address == SCH_OFF_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~req.writedata[SCH_IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_q | irq_set) & irq_mask_q);
      end
   end

   // Assertions
   AST_STANDBY_TIMED: assert property (@(posedge ref_clk) disable iff (rst)
      done_ev && cmd_q == SCH_CMD_STANDBY |=> standby_q)
      else $error("timed standby not entered");
   AST_STANDBY_NOW: assert property (@(posedge ref_clk) disable iff (rst)
      done_ev && cmd_q == SCH_CMD_STANDBY_NOW |=> standby_q)
      else $error("immediate standby not entered");
   AST_TIMER_ON: assert property (@(posedge ref_clk) disable iff (rst)
      tmr_load && count_q != 8'h00 |=> timer_en_q)
      else $error("timer not enabled");
   AST_TIMER_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      tmr_load && count_q == 8'h00 |=> !timer_en_q)
      else $error("timer not disabled");
   AST_OK_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
      done_ev |=> status_q[SCH_ST_DRDY] && !status_q[SCH_ST_BSY] && !status_q[SCH_ST_DF] && !status_q[SCH_ST_DRQ])
      else $error("bad success status");
   AST_NO_PM_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == SCH_EXEC && !ctrl_q[SCH_CT_PM_SUP] |=> error_q[SCH_ER_ABRT])
      else $error("abort flag missing");
   AST_ABORT_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
      abort_ev |=> !status_q[SCH_ST_BSY] && status_q[SCH_ST_DRDY] && status_q[SCH_ST_DF] == $past(ctrl_q[SCH_CT_FAULT]))
      else $error("bad abort status");
   AST_ERR_BIT: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == SCH_DONE |-> status_q[SCH_ST_ERR] == (error_q != 8'h00))
      else $error("error bit mismatch");
   AST_DEV_SHOWN: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> drive_sel_q == $past(drvsel_q[SCH_DH_DEV]))
      else $error("drive select not shown");
   AST_BUSY_SPAN: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == SCH_IDLE && cmd_wr && status_q[SCH_ST_DRDY] |=> status_q[SCH_ST_BSY] ##1 !status_q[SCH_ST_BSY])
      else $error("busy span wrong");

   COV_TIMED: cover property (@(posedge ref_clk) disable iff (rst) tmr_load && count_q != 8'h00);
   COV_NOW: cover property (@(posedge ref_clk) disable iff (rst) done_ev && cmd_q == SCH_CMD_STANDBY_NOW);
   COV_ABORT: cover property (@(posedge ref_clk) disable iff (rst) abort_ev);
   COV_EXPIRE: cover property (@(posedge ref_clk) disable iff (rst) expire);
endmodule : sch_handler

/* rtl/sch_pkg.sv */
/*
 Package for the standby command handler: register map, status and error bit
 positions, command codes, state encoding and bus/status carriers.
 Assumes a single 25 MHz clock domain and an Avalon-MM register bus.
*/
package sch_pkg;
   // Register word offsets (byte address = offset)
   localparam logic [4:0] SCH_OFF_COUNT = 5'h00;
   localparam logic [4:0] SCH_OFF_DRVSEL = 5'h04;
   localparam logic [4:0] SCH_OFF_CMD = 5'h08;
   localparam logic [4:0] SCH_OFF_STATUS = 5'h0c;
   localparam logic [4:0] SCH_OFF_ERROR = 5'h10;
   localparam logic [4:0] SCH_OFF_CTRL = 5'h14;
   localparam logic [4:0] SCH_OFF_IRQ_STAT = 5'h18;
   localparam logic [4:0] SCH_OFF_IRQ_MASK = 5'h1c;
   // Status bits
   localparam int SCH_ST_BSY = 7;
   localparam int SCH_ST_DRDY = 6;
   localparam int SCH_ST_DF = 5;
   localparam int SCH_ST_DRQ = 3;
   localparam int SCH_ST_ERR = 0;
   // Error bits
   localparam int SCH_ER_ABRT = 2;
   // Drive select bit in drive_select_head
   localparam int SCH_DH_DEV = 4;
   // Control register bits
   localparam int SCH_CT_PM_SUP = 0;
   localparam int SCH_CT_FAULT = 1;
   localparam int SCH_CT_CANT = 2;
   // Interrupt status bits
   localparam int SCH_IRQ_DONE = 0;
   localparam int SCH_IRQ_ABORT = 1;
   localparam int SCH_IRQ_EXPIRE = 2;
   localparam int SCH_IRQ_W = 3;
   // Command codes
   localparam logic [7:0] SCH_CMD_STANDBY = 8'he2;
   localparam logic [7:0] SCH_CMD_STANDBY_NOW = 8'he0;
   // Reset values and timer width
   localparam logic [7:0] SCH_STATUS_RST = 8'h40;
   localparam logic [2:0] SCH_CTRL_RST = 3'h1;
   localparam int SCH_TMR_W = 24;

   typedef enum logic [1:0] {
      SCH_IDLE = 2'b00,
      SCH_EXEC = 2'b01,
      SCH_DONE = 2'b11
   } sch_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } sch_req_t;

   typedef struct packed {
      logic standby;
      logic timer_en;
   } sch_pwr_t;
endpackage : sch_pkg

/* rtl/sch_timer.sv */
/*
 Standby countdown timer: loads a period, counts down while enabled and
 pulses on expiry. Assumes load and period come from the command handler.
*/
`timescale 1ns/100ps
module sch_timer #(
   parameter int W = 24
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic enable,
   input wire logic [W-1:0] period,
   input wire logic restart,
   output logic expire
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] per_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         per_q <= '0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (load) begin
            per_q <= period;
            cnt_q <= period;
         end else if (restart) begin
            cnt_q <= per_q;
         end else if (enable && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == W'(1)) begin
               expire <= 1'b1;
            end
         end
      end
   end
endmodule : sch_timer

/* testbench/sch_host.sv */
/*
 Host adapter model: Avalon-MM master that drives the standby handler registers.
 Assumes its tasks are called just after a rising edge of ref_clk.
*/
`timescale 1ns/100ps
module sch_host
   import sch_pkg::*;
(
   input wire logic ref_clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output sch_pkg::sch_req_t req
);
   initial req = '0;

   // One access, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      req <= '{read: !wr, write: wr, address: a, writedata: d};
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      req <= '0;
      @(posedge ref_clk);
   endtask : xfer

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask : rd

   // Poll until not busy and ready
   task automatic wait_ready;
      logic [31:0] s;
      s = '0;
      for (int i = 0; i < 20 && (s[SCH_ST_BSY] !== 1'b0 || s[SCH_ST_DRDY] !== 1'b1); i++) rd(SCH_OFF_STATUS, s);
   endtask : wait_ready

   // Count first for the timed standby code only, then the code, only while ready
   task automatic issue(input logic [7:0] count, input logic [7:0] code);
      wait_ready();
      if (code == SCH_CMD_STANDBY) wr(SCH_OFF_COUNT, {24'h0, count});
      wr(SCH_OFF_CMD, {24'h0, code});
      wait_ready();
   endtask : issue
endmodule : sch_host

/* testbench/test_standby_command_handler.sv */
/*
 Self-checking bench for the standby command handler.
 Assumes the package, timer, handler and host model are compiled before it.
*/
`timescale 1ns/100ps
module test_standby_command_handler;
   import sch_pkg::*;
   logic ref_clk;
   logic rst;
   logic activity;
   sch_req_t req;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic standby_q;
   logic timer_en_q;
   logic drive_sel_q;
   logic irq;
   int n_mismatch;
   int n_checks;
   logic [7:0] dsv [2] = '{8'h10, 8'hef};
   logic [7:0] ctl [4] = '{8'h00, 8'h02, 8'h05, 8'h03};
   logic [7:0] est [4] = '{8'h41, 8'h61, 8'h41, 8'h40};
   logic [7:0] eer [4] = '{8'h04, 8'h04, 8'h04, 8'h00};
   logic [7:0] codes [2] = '{SCH_CMD_STANDBY, SCH_CMD_STANDBY_NOW};

   sch_handler #(.PERIOD_LUT('{default: 24'h000005})) sch_handler_i (
      .ref_clk(ref_clk), .rst(rst), .avs_address(req.address), .avs_read(req.read),
      .avs_write(req.write), .avs_writedata(req.writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .activity(activity), .standby_q(standby_q),
      .timer_en_q(timer_en_q), .drive_sel_q(drive_sel_q), .irq(irq));

   sch_host sch_host_i (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .req(req));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      sch_host_i.rd(a, q);
      check(what, q, exp);
   endtask : rchk

   task automatic result(input logic [7:0] st, input logic [7:0] er);
      rchk("status", SCH_OFF_STATUS, {24'h0, st});
      rchk("error", SCH_OFF_ERROR, {24'h0, er});
   endtask : result

   task automatic wake;
      activity <= 1'b1;
      @(posedge ref_clk);
      activity <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : wake

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Whole run needs a few hundred cycles
   initial begin
      #800000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      int k;
      rst = 1'b1;
      activity = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      result(8'h40, 8'h00);
      rchk("ctrl", SCH_OFF_CTRL, 32'h1);
      check("standby", standby_q, 1'b0);
      $display("test reset done");
      foreach (dsv[i]) begin
         sch_host_i.wr(SCH_OFF_DRVSEL, {24'h0, dsv[i]});
         rchk("drvsel", SCH_OFF_DRVSEL, {24'h0, dsv[i]});
         check("drive_sel_q", drive_sel_q, dsv[i][SCH_DH_DEV]);
      end
      $display("test drive select done");
      sch_host_i.issue(8'h00, SCH_CMD_STANDBY);
      result(8'h40, 8'h00);
      check("standby", standby_q, 1'b1);
      check("timer_en", timer_en_q, 1'b0);
      rchk("cmd", SCH_OFF_CMD, 32'h0);
      sch_host_i.issue(8'h01, SCH_CMD_STANDBY);
      rchk("count", SCH_OFF_COUNT, 32'h1);
      check("timer_en", timer_en_q, 1'b1);
      activity <= 1'b1;
      @(posedge ref_clk);
      activity <= 1'b0;
      for (k = 0; k < 10 && standby_q !== 1'b0; k++) @(posedge ref_clk);
      check("left standby", standby_q, 1'b0);
      for (k = 0; k < 40 && standby_q !== 1'b1; k++) @(posedge ref_clk);
      check("timed standby", standby_q, 1'b1);
      check("period", 32'(k >= 4 && k <= 8), 32'h1);
      $display("test timed standby done");
      rchk("irq stat", SCH_OFF_IRQ_STAT, 32'h5);
      check("irq masked", irq, 1'b0);
      sch_host_i.wr(SCH_OFF_IRQ_MASK, 32'h4);
      @(posedge ref_clk);
      check("irq", irq, 1'b1);
      sch_host_i.wr(SCH_OFF_IRQ_STAT, 32'h4);
      @(posedge ref_clk);
      check("irq cleared", irq, 1'b0);
      rchk("irq stat", SCH_OFF_IRQ_STAT, 32'h1);
      sch_host_i.wr(SCH_OFF_IRQ_MASK, 32'h0);
      $display("test interrupt done");
      sch_host_i.issue(8'h00, SCH_CMD_STANDBY);
      check("timer off", timer_en_q, 1'b0);
      wake();
      repeat (10) @(posedge ref_clk);
      check("awake", standby_q, 1'b0);
      sch_host_i.issue(8'h00, SCH_CMD_STANDBY_NOW);
      check("standby now", standby_q, 1'b1);
      result(8'h40, 8'h00);
      $display("test immediate done");
      for (int i = 0; i < 4; i++) begin
         foreach (codes[j]) begin
            sch_host_i.wr(SCH_OFF_CTRL, {24'h0, ctl[i]});
            sch_host_i.issue(8'h01, codes[j]);
            result(est[i], eer[i]);
         end
      end
      rchk("irq stat", SCH_OFF_IRQ_STAT, 32'h3);
      sch_host_i.wr(SCH_OFF_CTRL, 32'h1);
      $display("test abort done");
      rchk("unmapped", 5'h02, 32'h0);
      sch_host_i.wr(SCH_OFF_STATUS, 32'hff);
      rchk("status ro", SCH_OFF_STATUS, 32'h40);
      $display("test map done");
      wrap_up();
   end
endmodule : test_standby_command_handler
